// >>> motion_model.sv
`timescale 1ns/1ps
module motion_model #(parameter int AXES = 4, parameter int DECEL = 8) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic [AXES-1:0]   run,
  input wire logic [2:0]        mode_cmd,
  input wire logic [AXES*2-1:0] act,
  output logic     [AXES*3-1:0] axis_mode,
  output logic     [AXES-1:0]   axis_moving
);
  logic [AXES-1:0] run_q;
  int              cnt_q [AXES];
  assign axis_mode = {AXES{mode_cmd}};
  // an axis starts only on a fresh run request, so a stopped axis stays stopped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q       <= '0;
      axis_moving <= '0;
      for (int i = 0; i < AXES; i++) cnt_q[i] <= 0;
    end else begin
      run_q <= run;
      for (int i = 0; i < AXES; i++) begin
        if (!run[i] || act[2*i+:2] == 2'h2) begin
          axis_moving[i] <= 1'b0;
          cnt_q[i]       <= 0;
        end else if (act[2*i+:2] == 2'h1) begin
          cnt_q[i] <= DECEL;
        end else if (cnt_q[i] > 1) begin
          cnt_q[i] <= cnt_q[i] - 1;
        end else if (cnt_q[i] == 1) begin
          cnt_q[i]       <= 0;
          axis_moving[i] <= 1'b0;
        end else if (!run_q[i]) begin
          axis_moving[i] <= 1'b1;
        end
      end
    end
  end
endmodule : motion_model

// >>> pos_err_map.svh
`ifndef POS_ERR_MAP_SVH
`define POS_ERR_MAP_SVH
// register byte offsets
`define PEM_CTRL_OFF      12'h000
`define PEM_STATUS_OFF    12'h004
`define PEM_ERR_BASE_OFF  12'h040
// control register fields
`define PEM_CTRL_READY_BIT  0
`define PEM_CTRL_TEST_BIT   1
`define PEM_CTRL_RESET      32'h0000_0000
// axis register field positions (write side: [0] stop, [1] rapid stop, [2] clear error)
`define PEM_AX_STOP_BIT   0
`define PEM_AX_RSTOP_BIT  1
`define PEM_AX_CLR_BIT    2
// axis register read side: error code field lsb
`define PEM_AX_CODE_LSB   16
// error codes
`define PEM_ERR_NONE      9'h000
`define PEM_ERR_RDY_RUN   9'h0c8
`define PEM_ERR_RDY_HOME  9'h0c9
`define PEM_ERR_STOP_HOME 9'h0ca
`define PEM_ERR_RSTP_HOME 9'h0cb
`define PEM_ERR_RDY_DECEL 9'h0cc
`define PEM_ERR_TEST_HOME 9'h0ce
`endif

// >>> pos_err_pkg.sv
package pos_err_pkg;
  typedef enum logic [2:0] {
    MODE_IDLE      = 3'b000,
    MODE_POSITION  = 3'b001,
    MODE_HOME      = 3'b010,
    MODE_FIXSTOP   = 3'b011,
    MODE_OTHER     = 3'b100
  } axis_mode_e;
  typedef enum logic [1:0] {
    ACT_NONE  = 2'b00,
    ACT_DECEL = 2'b01,
    ACT_RAPID = 2'b10
  } stop_act_e;
endpackage : pos_err_pkg

// >>> positioning_error_monitor.sv
// Overview of operation
// RULE1: errors found while an axis runs are recorded as codes 200 to 299, apart from start errors.
// RULE2: ready flag falling during servo-program motion other than home return or fixed-stop speed records 200.
// RULE3: ready flag falling during home return records 201 and requests a deceleration stop.
// RULE4: to retry after 201 the host reasserts ready or releases stop requests before restarting home return.
// RULE5: axis stop request rising during home return records 202.
// RULE6: axis rapid-stop request rising during home return records 203 and requests a rapid stop.
// RULE7: ready flag reasserted while axes still decelerate from a ready drop records 204 and is ignored.
// RULE8: the host reasserts the ready flag only after every axis has stopped.
// RULE9: test-mode all-axes rapid stop during home return records 206 and rapid-stops the axis.
// RULE10: the error code stays readable until software clears it; a newer error overwrites it.
`timescale 1ns/1ps
`include "pos_err_map.svh"
module positioning_error_monitor
  import pos_err_pkg::*;
#(
  parameter int AXES = 4
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic [AXES*3-1:0]   axis_mode,
  input  wire logic [AXES-1:0]     axis_moving,
  input  wire logic                test_rapid_stop,
  output logic      [AXES*2-1:0]   axis_stop_action
);
  localparam int AW = (AXES > 1) ? $clog2(AXES) : 1;

  logic [1:0]       test_sync_q;
  logic [AXES-1:0]  moving_sync1_q;
  logic [AXES-1:0]  moving_q;
  logic [AXES*3-1:0] mode_sync1_q;
  logic [AXES*3-1:0] mode_q;
  logic             test_prev_q;
  logic             controller_ready_flag_q;
  logic             ready_prev_q;
  logic             ready_decel_q;
  logic [AXES-1:0]  axis_stop_request_q;
  logic [AXES-1:0]  axis_rapid_stop_request_q;
  logic [AXES-1:0]  stop_prev_q;
  logic [AXES-1:0]  rstop_prev_q;
  logic [8:0]       err_code_q [AXES];
  logic [AXES-1:0]  err_clr;

  // per-axis decode results, next values of the error record and the action
  axis_mode_e        md [AXES];
  logic [8:0]        code [AXES];
  stop_act_e         act [AXES];
  logic [AXES*2-1:0] action_d;

  wire bus_wr = psel & penable & pwrite;
  wire ax_hit = (paddr >= `PEM_ERR_BASE_OFF) && (paddr < `PEM_ERR_BASE_OFF + 12'(AXES * 4));
  wire [AW-1:0] ax_idx = AW'((paddr - `PEM_ERR_BASE_OFF) >> 2);

  function automatic axis_mode_e mode_of(input logic [AXES*3-1:0] m, input int n);
    mode_of = axis_mode_e'(m[n*3 +: 3]);
  endfunction : mode_of

  // external levels from the motion generator pass two flops before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      test_sync_q    <= 2'h0;
      moving_sync1_q <= '0;
      moving_q       <= '0;
      mode_sync1_q   <= '0;
      mode_q         <= '0;
      test_prev_q    <= 1'b0;
    end else begin
      test_sync_q    <= {test_sync_q[0], test_rapid_stop};
      moving_sync1_q <= axis_moving;
      moving_q       <= moving_sync1_q;
      mode_sync1_q   <= axis_mode;
      mode_q         <= mode_sync1_q;
      test_prev_q    <= test_sync_q[1];
    end
  end

  // edges are taken on the synchronised copy so a slow pin edge yields one event;
  // the edge flops reset to the idle level, so no false edge follows reset
  wire test_rise = test_sync_q[1] & ~test_prev_q;

  // host flags written over the bus; an axis write always rewrites both request
  // bits, so software must write back the levels it wants to keep
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      controller_ready_flag_q   <= 1'b0;
      axis_stop_request_q       <= '0;
      axis_rapid_stop_request_q <= '0;
    end else if (bus_wr) begin
      if (paddr == `PEM_CTRL_OFF)
        controller_ready_flag_q <= pwdata[`PEM_CTRL_READY_BIT];
      if (ax_hit) begin
        axis_stop_request_q[ax_idx]       <= pwdata[`PEM_AX_STOP_BIT];
        axis_rapid_stop_request_q[ax_idx] <= pwdata[`PEM_AX_RSTOP_BIT];
      end
    end
  end

  always_comb begin
    err_clr = '0;
    if (bus_wr && ax_hit && pwdata[`PEM_AX_CLR_BIT])
      err_clr[ax_idx] = 1'b1;
  end

  // ready edges come from the flag register itself, so they line up with the bus write
  wire ready_fall = ready_prev_q & ~controller_ready_flag_q;
  wire ready_rise = ~ready_prev_q & controller_ready_flag_q;

  // deceleration window after ready drop lasts until every axis has stopped;
  // one moving axis keeps the window open for all of them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_prev_q  <= 1'b0;
      ready_decel_q <= 1'b0;
      stop_prev_q   <= '0;
      rstop_prev_q  <= '0;
    end else begin
      ready_prev_q <= controller_ready_flag_q;
      stop_prev_q  <= axis_stop_request_q;
      rstop_prev_q <= axis_rapid_stop_request_q;
      if (ready_fall && (|moving_q))
        ready_decel_q <= 1'b1;
      else if (!(|moving_q))
        ready_decel_q <= 1'b0;
    end
  end

  // per-axis event decode; inside home return a test stop outranks a rapid stop,
  // which outranks a ready drop, which outranks a plain stop request
  always_comb begin
    for (int n = 0; n < AXES; n++) begin
      md[n]   = mode_of(mode_q, n);
      code[n] = `PEM_ERR_NONE;
      act[n]  = ACT_NONE;
      if (moving_q[n]) begin
        if (md[n] == MODE_HOME) begin
          if (test_rise) begin
            code[n] = `PEM_ERR_TEST_HOME; // RULE9
            act[n]  = ACT_RAPID;
          end else if (axis_rapid_stop_request_q[n] && !rstop_prev_q[n]) begin
            code[n] = `PEM_ERR_RSTP_HOME; // RULE6
            act[n]  = ACT_RAPID;
          end else if (ready_fall) begin
            code[n] = `PEM_ERR_RDY_HOME; // RULE3
            act[n]  = ACT_DECEL;
          end else if (axis_stop_request_q[n] && !stop_prev_q[n]) begin
            code[n] = `PEM_ERR_STOP_HOME; // RULE5
            act[n]  = ACT_DECEL;
          end
        end else if (ready_fall && md[n] != MODE_FIXSTOP && md[n] != MODE_IDLE) begin
          code[n] = `PEM_ERR_RDY_RUN; // RULE2
          act[n]  = ACT_DECEL;
        end
      end
      // a ready reassertion inside the window is only reported, never acted on,
      // so every axis keeps decelerating to a full stop
      if (code[n] == `PEM_ERR_NONE && ready_rise && ready_decel_q) begin
        code[n] = `PEM_ERR_RDY_DECEL; // RULE7
        act[n]  = ACT_NONE;
      end
      action_d[n*2 +: 2] = act[n];
    end
  end

  // the stop action is a one-cycle command; the motion generator latches it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      axis_stop_action <= '0;
    end else begin
      axis_stop_action <= action_d;
    end
  end

  // latest event overwrites, and an event beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int n = 0; n < AXES; n++) begin
        err_code_q[n] <= `PEM_ERR_NONE;
      end
    end else begin
      for (int n = 0; n < AXES; n++) begin
        if (code[n] != `PEM_ERR_NONE) begin
          err_code_q[n] <= code[n]; // RULE1 RULE10
        end else if (err_clr[n]) begin
          err_code_q[n] <= `PEM_ERR_NONE; // RULE10
        end
      end
    end
  end

  // apb slave: zero wait, unmapped reads zero with pslverr;
  // a refused write changes nothing, only the response flags it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && !penable) begin
        if (paddr == `PEM_CTRL_OFF)
          prdata <= {31'h0, controller_ready_flag_q};
        else if (paddr == `PEM_STATUS_OFF)
          prdata <= {15'h0, ready_decel_q, 8'h0, 8'(moving_q)};
        else if (ax_hit)
          prdata <= {7'h0, err_code_q[ax_idx], 14'h0,
                     axis_rapid_stop_request_q[ax_idx], axis_stop_request_q[ax_idx]};
        else
          pslverr <= 1'b1;
      end
    end
  end
endmodule : positioning_error_monitor

// >>> positioning_error_monitor_sva.sv
`timescale 1ns/1ps
module positioning_error_monitor_sva #(parameter int AXES = 4) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [11:0]       paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [AXES*3-1:0] axis_mode,
  input wire logic [AXES-1:0]   axis_moving,
  input wire logic              test_rapid_stop,
  input wire logic [AXES*2-1:0] axis_stop_action
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [3:0] h_q;
  logic       rs_q;
  wire        wr0 = psel && penable && pwrite && paddr == 12'h040;
  wire [1:0]  a0 = axis_stop_action[1:0];
  // home motion must be seen for a while so the input synchronisers agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      h_q <= 4'h0;
      rs_q <= 1'b0;
    end else begin
      h_q <= {h_q[2:0], axis_moving[0] && axis_mode[2:0] == 3'h2};
      if (wr0) rs_q <= pwdata[1];
    end
  end
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready late");
  property p_pls; pready |=> !pready; endproperty
  a_pls: assert property (p_pls) else $error("pready held");
  property p_src; pready |-> $past(psel && !penable); endproperty
  a_src: assert property (p_src) else $error("pready unasked");
  property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("bad refusal");
  property p_lgl; a0 != 2'h3; endproperty
  a_lgl: assert property (p_lgl) else $error("bad action");
  property p_one; a0 != 2'h0 |=> a0 == 2'h0; endproperty
  a_one: assert property (p_one) else $error("action held");
  property p_tst; $rose(test_rapid_stop) && &h_q |-> ##[2:7] a0 == 2'h2; endproperty
  a_tst: assert property (p_tst) else $error("no test stop");
  property p_rst; wr0 && pwdata[1] && !rs_q && &h_q |=> ##[0:4] a0 == 2'h2; endproperty
  a_rst: assert property (p_rst) else $error("no rapid stop");
endmodule : positioning_error_monitor_sva
bind positioning_error_monitor positioning_error_monitor_sva #(.AXES(AXES)) chk_i (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .axis_mode(axis_mode), .axis_moving(axis_moving),
  .test_rapid_stop(test_rapid_stop), .axis_stop_action(axis_stop_action));

// >>> positioning_error_monitor_tb.sv
`timescale 1ns/1ps
`include "pos_err_map.svh"
module positioning_error_monitor_tb;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, tst = 0, e;
  logic [11:0] paddr = 12'h0, axis_mode;
  logic [31:0] pwdata = 32'h0, prdata, d;
  logic        pready, pslverr;
  logic [2:0]  mode = 3'h0;
  logic [3:0]  run = 4'h0, axis_moving;
  logic [7:0]  act;
  int          n_mismatch = 0, comparisons = 0;
  localparam logic [11:0] B = `PEM_ERR_BASE_OFF;
  localparam logic [11:0] C = `PEM_CTRL_OFF;
  initial forever #2 pclk = ~pclk;
  positioning_error_monitor positioning_error_monitor_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .axis_mode(axis_mode), .axis_moving(axis_moving), .test_rapid_stop(tst),
    .axis_stop_action(act));
  motion_model #(.DECEL(40)) motion_model_i (.pclk(pclk), .presetn(presetn), .run(run), .mode_cmd(mode),
    .act(act), .axis_mode(axis_mode), .axis_moving(axis_moving));
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // pready stands for the access cycle only: it and the read data are taken at that rising edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] v);
    int i;
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, v};
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      n_mismatch++;
      final_report();
    end
    {d, e} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask : xfer
  task automatic ck(input logic [11:0] a, input logic [8:0] x);
    xfer(1'b0, a, 32'h0);
    chk({23'h0, d[`PEM_AX_CODE_LSB +: 9]}, {23'h0, x});
  endtask : ck
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, C, 32'h0);
    chk(d, `PEM_CTRL_RESET);
    xfer(1'b0, 12'h008, 32'h0);
    chk({d[30:0], e}, 32'h1);
    xfer(1'b1, C, 32'h1);
    {mode, run} <= {3'h1, 4'h1};
    repeat (8) @(posedge pclk);
    xfer(1'b1, C, 32'h0);
    ck(B, `PEM_ERR_RDY_RUN);
    run <= 4'h0;
    repeat (8) @(posedge pclk);
    xfer(1'b1, C, 32'h1);
    ck(B + 12'h004, `PEM_ERR_NONE);
    {mode, run} <= {3'h2, 4'h1};
    repeat (8) @(posedge pclk);
    xfer(1'b1, C, 32'h0);
    ck(B, `PEM_ERR_RDY_HOME);
    xfer(1'b1, C, 32'h1);
    repeat (4) @(posedge pclk);
    xfer(1'b0, `PEM_STATUS_OFF, 32'h0);
    chk(d, 32'h0001_0001);
    for (int i = 0; i < 4; i++) ck(B + 12'(4 * i), `PEM_ERR_RDY_DECEL);
    repeat (50) @(posedge pclk);
    run <= 4'h0;
    xfer(1'b1, C, 32'h0);
    xfer(1'b1, C, 32'h1);
    {mode, run} <= {3'h3, 4'h1};
    repeat (8) @(posedge pclk);
    xfer(1'b1, C, 32'h0);
    ck(B, `PEM_ERR_RDY_DECEL);
    {mode, run} <= {3'h2, 4'h0};
    repeat (8) @(posedge pclk);
    xfer(1'b1, C, 32'h1);
    $display("ready tests done");
    run <= 4'h1;
    repeat (8) @(posedge pclk);
    xfer(1'b1, B, 32'h1);
    ck(B, `PEM_ERR_STOP_HOME);
    xfer(1'b1, B, 32'h2);
    ck(B, `PEM_ERR_RSTP_HOME);
    run <= 4'h0;
    xfer(1'b1, B, 32'h4);
    ck(B, `PEM_ERR_NONE);
    run <= 4'h1;
    repeat (8) @(posedge pclk);
    tst <= 1'b1;
    repeat (8) @(posedge pclk);
    tst <= 1'b0;
    ck(B, `PEM_ERR_TEST_HOME);
    $display("stop tests done");
    final_report();
  end
endmodule : positioning_error_monitor_tb
